// ### rtl/count_chain.v
`timescale 1ns/1ns
`include "timer_regs.vh"
module count_chain (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // Control
   input  wire        load,
   input  wire        tick,
   input  wire        dual,
   input  wire [15:0] latchVal,
   // Status
   output reg  [15:0] count,
   output wire        expiry
);
   wire lsbZero;
   wire msbZero;

   assign lsbZero = (count[7:0] == 8'h00);
   assign msbZero = (count[15:8] == 8'h00);
   // Time-out is the clock after the all-zero state
   assign expiry  = tick & lsbZero & msbZero;

   always @(posedge clk_sys) begin
      if (!resetn) begin
         count <= `RST_LATCH;
      end else if (load || expiry) begin
         count <= latchVal;
      end else if (tick) begin
         if (!dual) begin
            count <= count - 16'h0001;
         end else if (lsbZero) begin
            count[7:0]  <= latchVal[7:0];
            count[15:8] <= count[15:8] - 8'h01;
         end else begin
            count[7:0] <= count[7:0] - 8'h01;
         end
      end
   end
endmodule // count_chain

// ### rtl/gate_edge_sync.v
`timescale 1ns/1ns
module gate_edge_sync (
   // Clock and reset
   input  wire clk_sys,
   input  wire resetn,
   // Asynchronous pin
   input  wire pinIn,
   // Synchronised level and edges
   output wire level,
   output wire fall,
   output wire rise
);
   reg stage1;
   reg stage2;
   reg stage3;

   // Stage1 feeds only stage2 to keep metastability contained
   always @(posedge clk_sys) begin
      if (!resetn) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         stage3 <= 1'b1;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign level = stage2;
   assign fall  = stage3 & ~stage2;
   assign rise  = ~stage3 & stage2;
endmodule // gate_edge_sync

// ### rtl/timer_interval_measurement.v
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "timer_regs.vh"
module timer_interval_measurement (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // APB slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Pins
   input  wire        gatePin,
   input  wire        extResetN,
   output wire        timerOutputPin,
   // Interrupt
   output wire        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding

   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr[7:2] == off[7:2]);
      end
   endfunction

   function mapped;
      input [7:0] addr;
      begin
         mapped = hit(addr, `OFF_CTRL) | hit(addr, `OFF_LATCH) |
                  hit(addr, `OFF_COUNT) | hit(addr, `OFF_STATUS) |
                  hit(addr, `OFF_CLEAR) | hit(addr, `OFF_ENABLE) |
                  hit(addr, `OFF_STATE) | hit(addr, `OFF_PRESCALE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg  [7:0]  ctrl;
   reg  [15:0] latch;
   reg  [2:0]  status;
   reg  [2:0]  irqEnable;
   reg  [7:0]  prescale;
   reg  [7:0]  divCnt;
   reg         counting;
   reg         postTo;
   reg         outLevel;
   reg         firstDone;
   reg         next_counting;
   reg         next_postTo;
   reg         next_outLevel;
   reg         next_firstDone;
   reg         initNow;
   reg         flagSet;
   wire        accessPhase;
   wire        wrStrobe;
   wire        latchWrite;
   wire        clearWrite;
   wire        gateLevel;
   wire        gateFall;
   wire        gateRise;
   wire        extResetLevel;
   wire        timerReset;
   wire        measMode;
   wire        pwMode;
   wire        polarity;
   wire        dualMode;
   wire        tick;
   wire        expiry;
   wire        runExpiry;
   wire        endEdge;
   wire [15:0] count;
   wire [2:0]  irqSource;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   assign accessPhase = psel & penable;
   assign wrStrobe    = accessPhase & pwrite;
   assign latchWrite  = wrStrobe & hit(paddr, `OFF_LATCH);
   assign clearWrite  = wrStrobe & hit(paddr, `OFF_CLEAR);
   // Zero wait states; read data is captured in the setup cycle
   assign pready      = 1'b1;
   assign pslverr     = accessPhase & ~mapped(paddr);

   always @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl      <= `RST_CTRL;
         latch     <= `RST_LATCH;
         irqEnable <= `RST_ENABLE;
         prescale  <= `RST_PRESCALE;
      end else if (wrStrobe) begin
         if (hit(paddr, `OFF_CTRL)) begin
            ctrl <= pwdata[7:0];
         end
         if (hit(paddr, `OFF_LATCH)) begin
            latch <= pwdata[15:0];
         end
         if (hit(paddr, `OFF_ENABLE)) begin
            irqEnable <= pwdata[2:0];
         end
         if (hit(paddr, `OFF_PRESCALE)) begin
            prescale <= pwdata[7:0];
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata <= 32'h00000000;
         if (hit(paddr, `OFF_CTRL)) begin
            prdata[7:0] <= ctrl;
         end
         if (hit(paddr, `OFF_LATCH)) begin
            prdata[15:0] <= latch;
         end
         // Counter is readable in every mode, so software can fetch the width
         if (hit(paddr, `OFF_COUNT)) begin
            prdata[15:0] <= count;
         end
         if (hit(paddr, `OFF_STATUS)) begin
            prdata[2:0] <= status;
         end
         if (hit(paddr, `OFF_ENABLE)) begin
            prdata[2:0] <= irqEnable;
         end
         if (hit(paddr, `OFF_STATE)) begin
            prdata[`SV_COUNTING]   <= counting;
            prdata[`SV_POST_TO]    <= postTo;
            prdata[`SV_OUT_LEVEL]  <= outLevel;
            prdata[`SV_FIRST_DONE] <= firstDone;
            prdata[`SV_GATE]       <= gateLevel;
            prdata[`SV_RESET]      <= timerReset;
         end
         if (hit(paddr, `OFF_PRESCALE)) begin
            prdata[7:0] <= prescale;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // One clock of hold on each gate level is assumed here
   gate_edge_sync gateSync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pinIn   (gatePin),
      .level   (gateLevel),
      .fall    (gateFall),
      .rise    (gateRise)
   );

   // External reset reuses the synchroniser; its edge outputs are not needed
   gate_edge_sync resetSync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pinIn   (extResetN),
      .level   (extResetLevel),
      .fall    (),
      .rise    ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   assign timerReset = ctrl[`CTRL_SOFT_RESET] | ~extResetLevel;
   assign measMode   = ctrl[`CTRL_MEAS_SEL];
   assign pwMode     = ctrl[`CTRL_PW_SEL];
   assign polarity   = ctrl[`CTRL_POLARITY];
   assign dualMode   = ctrl[`CTRL_WIDTH_SEL];
   // Rising edge ends a pulse-width count, falling edge ends a period count
   assign endEdge    = pwMode ? gateRise : gateFall;

   ////////////////////////////////////////////////////////////////////////////
   // Count clock divider

   // Prescale of zero counts on every system clock
   assign tick = (divCnt == 8'h00);

   // Reload on initialization so the first tick of a count is a full period
   always @(posedge clk_sys) begin
      if (!resetn) begin
         divCnt <= 8'h00;
      end else if (tick || initNow) begin
         divCnt <= prescale;
      end else begin
         divCnt <= divCnt - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter

   count_chain counter (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .load     (initNow),
      .tick     (tick & counting),
      .dual     (dualMode),
      .latchVal (latch),
      .count    (count),
      .expiry   (expiry)
   );

   assign runExpiry = expiry & counting;

   ////////////////////////////////////////////////////////////////////////////
   // Measurement sequencing

   always @* begin
      next_counting  = counting;
      next_postTo    = postTo;
      next_outLevel  = outLevel;
      next_firstDone = firstDone;
      initNow        = 1'b0;
      flagSet        = 1'b0;
      if (timerReset) begin
         next_counting  = 1'b0;
         next_postTo    = 1'b0;
         next_outLevel  = 1'b0;
         next_firstDone = 1'b0;
         initNow        = 1'b1;
      end else if (!measMode || latchWrite) begin
         // A latch write stops the count and reloads the counter
         next_counting = 1'b0;
         initNow       = latchWrite;
      end else if (counting && !postTo && endEdge) begin
         // Gate edge beat the time-out
         if (!polarity) begin
            flagSet       = 1'b1;
            next_counting = 1'b0;
         end else if (!pwMode) begin
            initNow        = 1'b1;
            next_outLevel  = 1'b0;
            next_firstDone = 1'b0;
         end else begin
            next_counting = 1'b0;
         end
      end else if (runExpiry) begin
         // Time-out beat the gate edge
         if (polarity && !postTo) begin
            flagSet       = 1'b1;
            next_counting = 1'b0;
         end else begin
            next_postTo = 1'b1;
         end
         next_firstDone = 1'b1;
         next_outLevel  = firstDone ? ~outLevel : 1'b1;
      end else if (gateFall && !status[`ST_FLAG] && (!counting || postTo)) begin
         // A set flag holds off a new gate-started initialization; a latch write still reloads
         initNow        = 1'b1;
         next_counting  = 1'b1;
         next_postTo    = 1'b0;
         next_outLevel  = 1'b0;
         next_firstDone = 1'b0;
      end
   end

   always @(posedge clk_sys) begin
      if (!resetn) begin
         counting  <= 1'b0;
         postTo    <= 1'b0;
         outLevel  <= 1'b0;
         firstDone <= 1'b0;
      end else begin
         counting  <= next_counting;
         postTo    <= next_postTo;
         outLevel  <= next_outLevel;
         firstDone <= next_firstDone;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, clear and interrupt

   // Set beats a clear arriving in the same cycle
   always @(posedge clk_sys) begin
      if (!resetn) begin
         status <= 3'h0;
      end else begin
         if (clearWrite) begin
            status <= status & ~pwdata[2:0];
         end
         if (timerReset) begin
            status[`ST_FLAG] <= 1'b0;
         end
         if (flagSet) begin
            status[`ST_FLAG] <= 1'b1;
         end
         if (runExpiry) begin
            status[`ST_EXPIRY] <= 1'b1;
         end
         if (gateFall) begin
            status[`ST_GATE_FALL] <= 1'b1;
         end
      end
   end

   assign irqSource = status & irqEnable;
   assign irq = (irqSource[`ST_FLAG] & ctrl[`CTRL_IRQ_EN]) |
                irqSource[`ST_EXPIRY] | irqSource[`ST_GATE_FALL];

   ////////////////////////////////////////////////////////////////////////////
   // Output pin

   // Waveform is gated only at the pin; counting is unaffected
   assign timerOutputPin = outLevel & ctrl[`CTRL_OUT_EN];

endmodule // timer_interval_measurement

// ### rtl/timer_regs.vh
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// Register byte offsets
`define OFF_CTRL      8'h00
`define OFF_LATCH     8'h04
`define OFF_COUNT     8'h08
`define OFF_STATUS    8'h0c
`define OFF_CLEAR     8'h10
`define OFF_ENABLE    8'h14
`define OFF_STATE     8'h18
`define OFF_PRESCALE  8'h1c

// Control register fields
`define CTRL_SOFT_RESET   0
`define CTRL_WIDTH_SEL    2
`define CTRL_MEAS_SEL     3
`define CTRL_PW_SEL       4
`define CTRL_POLARITY     5
`define CTRL_IRQ_EN       6
`define CTRL_OUT_EN       7

// Status, clear and enable fields
`define ST_FLAG       0
`define ST_EXPIRY     1
`define ST_GATE_FALL  2

// State register fields
`define SV_COUNTING   0
`define SV_POST_TO    1
`define SV_OUT_LEVEL  2
`define SV_FIRST_DONE 3
`define SV_GATE       4
`define SV_RESET      5

// Reset values
`define RST_CTRL      8'h01
`define RST_LATCH     16'hffff
`define RST_ENABLE    3'h0
`define RST_PRESCALE  8'h00

`endif

// ### tb/gate_source.sv
`timescale 1ns/1ns
module gate_source (
   // Clock
   input  wire clk_sys,
   // Gate pin
   output reg  gatePin
);
   initial gatePin = 1'b1;
   // Levels change just after an edge and last whole cycles, so no edge is lost
   task automatic pulse(input int lowLen, input int highLen);
      gatePin <= 1'b0;
      repeat (lowLen) @(posedge clk_sys);
      gatePin <= 1'b1;
      repeat (highLen) @(posedge clk_sys);
   endtask
endmodule // gate_source

// ### tb/tb_top.sv
`timescale 1ns/1ns
`include "timer_regs.vh"
module tb_top;
   logic        clk_sys, resetn, psel, penable, pwrite, extResetN, perr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, gatePin, timerOutputPin, irq;
   int          err_count, cmp_count;

   timer_interval_measurement i_timer_interval_measurement (.clk_sys(clk_sys),
      .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gatePin(gatePin), .extResetN(extResetN), .timerOutputPin(timerOutputPin), .irq(irq));
   gate_source i_gate_source (.clk_sys(clk_sys), .gatePin(gatePin));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Request held from setup until pready is sampled high at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd   = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never drives psel twice in one step
      @(posedge clk_sys);
      if (k >= 50) begin
         err_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      check(rd, e);
   endtask
   task automatic rdf(input logic [7:0] a, input int b, input logic e);
      apb(a, 1'b0, 32'h0);
      check(rd[b], e);
   endtask
   // Soft reset clears old state, then the mode is armed
   task automatic setup(input logic [7:0] c, input logic [15:0] n);
      wr(`OFF_CTRL, 32'h01);
      wr(`OFF_LATCH, {16'h0, n});
      wr(`OFF_CLEAR, 32'h7);
      wr(`OFF_CTRL, {24'h0, c});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdchk(`OFF_CTRL, 32'h01);
      rdf(`OFF_STATE, `SV_RESET, 1'b1);
      rdchk(`OFF_LATCH, 32'hffff);
      rdchk(`OFF_ENABLE, 32'h0);
      rdchk(`OFF_STATUS, 32'h0);
      rdchk(`OFF_CLEAR, 32'h0);
      wr(`OFF_PRESCALE, 32'hab);
      rdchk(`OFF_PRESCALE, 32'hab);
      wr(`OFF_PRESCALE, 32'h0);
      rdchk(8'h20, 32'h0);
      check(perr, 1'b1);
      wr(`OFF_CTRL, 32'h00);
      i_gate_source.pulse(4, 4);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      $display("t_regs done");
   endtask
   task automatic t_p0_short;
      setup(8'hc8, 16'd40);
      wr(`OFF_ENABLE, 32'h1);
      i_gate_source.pulse(3, 10);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b1);
      i_gate_source.pulse(3, 10);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b1);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      check(irq, 1'b1);
      wr(`OFF_ENABLE, 32'h0);
      tick(1);
      check(irq, 1'b0);
      wr(`OFF_ENABLE, 32'h1);
      wr(`OFF_CLEAR, 32'h1);
      tick(1);
      check(irq, 1'b0);
      $display("t_p0_short done");
   endtask
   task automatic t_p0_long;
      setup(8'h88, 16'd40);
      i_gate_source.pulse(3, 3);
      check(timerOutputPin, 1'b0);
      tick(44);
      rdf(`OFF_STATE, `SV_POST_TO, 1'b1);
      check(timerOutputPin, 1'b1);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b0);
      tick(40);
      check(timerOutputPin, 1'b0);
      i_gate_source.pulse(3, 3);
      rdf(`OFF_STATE, `SV_POST_TO, 1'b0);
      check(timerOutputPin, 1'b0);
      wr(`OFF_CTRL, 32'h08);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b1);
      $display("t_p0_long done");
   endtask
   task automatic t_p1;
      setup(8'ha8, 16'd40);
      repeat (3) i_gate_source.pulse(5, 15);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b0);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b1);
      tick(40);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b1);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      i_gate_source.pulse(3, 3);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      wr(`OFF_CLEAR, 32'h1);
      i_gate_source.pulse(3, 3);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b1);
      $display("t_p1 done");
   endtask
   task automatic t_pw;
      setup(8'h18, 16'd40);
      i_gate_source.pulse(10, 4);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b1);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      apb(`OFF_COUNT, 1'b0, 32'h0);
      check(rd < 32'd40 && rd > 32'd25, 1'b1);
      setup(8'h38, 16'd40);
      i_gate_source.pulse(10, 4);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b0);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      i_gate_source.pulse(60, 4);
      rdf(`OFF_STATUS, `ST_FLAG, 1'b1);
      $display("t_pw done");
   endtask
   // Latch 0x0203 expires after 12 ticks as two bytes, 516 as one word
   task automatic t_dual;
      setup(8'h0c, 16'h0203);
      i_gate_source.pulse(3, 20);
      rdf(`OFF_STATE, `SV_POST_TO, 1'b1);
      setup(8'h08, 16'h0203);
      i_gate_source.pulse(3, 20);
      rdf(`OFF_STATE, `SV_POST_TO, 1'b0);
      $display("t_dual done");
   endtask
   task automatic t_reset;
      setup(8'h88, 16'd40);
      i_gate_source.pulse(3, 3);
      extResetN <= 1'b0;
      tick(5);
      rdf(`OFF_STATE, `SV_RESET, 1'b1);
      extResetN <= 1'b1;
      tick(3);
      rdf(`OFF_STATE, `SV_COUNTING, 1'b0);
      check(timerOutputPin, 1'b0);
      wr(`OFF_CTRL, 32'h89);
      rdf(`OFF_STATE, `SV_RESET, 1'b1);
      $display("t_reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      err_count++;
      close_out();
   end
   initial begin
      resetn    = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      extResetN = 1'b1;
      err_count = 0;
      cmp_count = 0;
      tick(4);
      resetn <= 1'b1;
      tick(3);
      t_regs();
      t_p0_short();
      t_p0_long();
      t_p1();
      t_pw();
      t_dual();
      t_reset();
      close_out();
   end
endmodule // tb_top

// ### tb/timer_interval_measurement_asserts.sv
`timescale 1ns/1ns
module timer_interval_measurement_asserts (
   // Clock and reset
   input wire        clk_sys,
   input wire        resetn,
   // APB
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins
   input wire        gatePin,
   input wire        extResetN,
   input wire        timerOutputPin,
   input wire        irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_wr(logic [5:0] a);
      s_acc ##0 (pwrite && paddr[7:2] == a);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_zero_wait: assert property (psel |-> pready) else $error("pready low");
   a_err_unmapped: assert property (s_acc ##0 paddr >= 8'h20 |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (s_acc ##0 paddr < 8'h20 |-> !pslverr)
      else $error("error on mapped access");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
   a_clear_reads: assert property (s_acc ##0 (!pwrite && paddr[7:2] == 6'h4) |-> prdata == 32'h0)
      else $error("clear register read nonzero");
   a_outen_gates: assert property (s_wr(6'h0) ##0 !pwdata[7] |=> !timerOutputPin [*2])
      else $error("output driven while disabled");
   a_soft_reset_out: assert property (s_wr(6'h0) ##0 pwdata[0] |-> ##2 !timerOutputPin)
      else $error("output high in soft reset");
   a_ext_reset_out: assert property (!extResetN [*4] |=> !timerOutputPin)
      else $error("output high in external reset");
   a_irq_masked: assert property (s_wr(6'h5) ##0 pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq high while masked");
   // Reset itself must quiet the outputs, so this one is not disabled by it
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !irq && !timerOutputPin)
      else $error("outputs active after reset");
endmodule // timer_interval_measurement_asserts

bind timer_interval_measurement timer_interval_measurement_asserts
   i_timer_interval_measurement_asserts (.clk_sys, .resetn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .prdata, .pready, .pslverr, .gatePin, .extResetN, .timerOutputPin, .irq);
